// ==== core/fpk_pkg.sv ====
// Purpose: Shared constants and types for the front panel key controller.
// Assumes: pclk runs at 10 MHz; APB slave with 32-bit data.
// Notes: Times are in milliseconds; cycle counts derive from CLK_KHZ.
`default_nettype none

package fpk_pkg;
	localparam int CLK_KHZ = 10_000;
	localparam int DEBOUNCE_MS = 10;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
	localparam int REPEAT_MS = 250;
	localparam int REPEAT_CYC = REPEAT_MS * CLK_KHZ;
	localparam int MESSAGE_MS = 1000;
	localparam int MESSAGE_CYC = MESSAGE_MS * CLK_KHZ;
	localparam int BLINK_MS = 200;
	localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;

	// Positions on the raw key bus
	localparam int NKEY = 10;
	localparam int KEY_DISPLAY = 0;
	localparam int KEY_SEL0 = 1;
	localparam int KEY_GAIN = 7;
	localparam int KEY_UP = 8;
	localparam int KEY_DOWN = 9;
	localparam int NSEL = 6;
	localparam logic [2:0] SEL_SHIFT = 3'h0;
	localparam logic [2:0] SEL_MODE = 3'h1;
	localparam int NDISP = 6;
	localparam int DISP_SHIFT = 1;

	localparam int MAG_W = 10;
	localparam logic [9:0] MAG_FULL = 10'h3e8;
	localparam logic [9:0] STEP_SMALL = 10'h001;
	localparam logic [9:0] STEP_LARGE = 10'h00a;
	localparam logic [3:0] SMALL_STEP_LIMIT = 4'ha;

	// Sensitivity index: 0 is 5 V, each step 5-2-1 more sensitive, 20 is 1 uV
	localparam int SENS_W = 5;
	localparam logic [4:0] SENS_LAST = 5'h14;
	localparam logic [4:0] SENS_STABLE_HI = 5'h0e;
	localparam logic [4:0] SENS_MID_LO = 5'h06;
	localparam logic [4:0] SENS_MID_HI = 5'h11;
	localparam logic [4:0] SENS_MAXHR_LO = 5'h09;

	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SENS = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_SHIFT = 8'h0c;
	localparam int CTRL_TWOCH_BIT = 0;
	localparam int CTRL_OMODE_LSB = 1;

	localparam int HOLD_ERR = 0;
	localparam int HOLD_HR = 1;
	localparam int HOLD_SENS = 2;
	localparam int NHOLD = 3;

	typedef enum logic [1:0] {SIGN_OFF, SIGN_POS, SIGN_NEG} fpk_sign_t;
	typedef enum logic [1:0] {HR_STABLE, HR_MIDDLE, HR_MAX} fpk_headroom_t;
	typedef enum logic [1:0] {RNG_WIDE, RNG_MID, RNG_LOW} fpk_range_t;
	typedef enum logic [1:0] {
		OMODE_INPHASE, OMODE_TRACK, OMODE_MAG, OMODE_LOGMAG
	} fpk_omode_t;
	typedef enum logic [1:0] {
		MTR_VALUE, MTR_SHIFT, MTR_OFF, MTR_MISSING_CARD
	} fpk_meter_t;
	typedef enum logic [2:0] {
		REG_CTRL, REG_SENS, REG_STATUS, REG_SHIFT, REG_NONE
	} fpk_reg_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} fpk_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} fpk_apb_rsp_t;

	typedef struct packed {
		logic [NDISP-1:0] disp_led;
		logic [NSEL-1:0] sel_led;
		logic [2*NSEL-1:0] subsel_led;
		logic shift_pos_led;
		logic shift_neg_led;
		logic gain_led;
		logic [2:0] headroom_led;
		logic [2:0] range_led;
		logic sens_flash;
		logic shift_to_mag;
		fpk_meter_t meter_mode;
		logic meter_neg;
		logic [MAG_W-1:0] meter_mag;
	} fpk_panel_out_t;
endpackage

`default_nettype wire

// ==== core/fpk_key_cond.sv ====
// Purpose: Synchronise, debounce and edge-detect one front-panel key.
// Assumes: key_raw is high while pressed and is asynchronous to pclk.
// Notes: Repeat pulses start one interval after the press and continue.
`timescale 1ns/100ps
`default_nettype none

module fpk_key_cond #(
	parameter int DEB_CYC = fpk_pkg::DEBOUNCE_CYC,
	parameter int RPT_CYC = fpk_pkg::REPEAT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic key_raw,
	output var logic held,
	output var logic press,
	output var logic repeat_pulse
);
	import fpk_pkg::*;

	localparam int DW = $clog2(DEB_CYC + 1);
	localparam int RW = $clog2(RPT_CYC + 1);

	if (DEB_CYC < 1 || RPT_CYC < 1) begin : g_chk
		$error("Debounce and repeat counts must be at least one");
	end

	typedef struct packed {
		logic s1;
		logic s2;
		logic lvl;
		logic press;
		logic rpt;
		logic [DW-1:0] deb_cnt;
		logic [RW-1:0] rpt_cnt;
	} fpk_key_state_t;

	fpk_key_state_t q, d;

	always_comb begin
		d = q;
		d.s1 = key_raw;
		d.s2 = q.s1;
		d.press = 1'b0;
		d.rpt = 1'b0;
		// A level must stay changed for the whole window to count
		if (q.s2 != q.lvl) begin
			if (q.deb_cnt == DW'(DEB_CYC - 1)) begin
				d.lvl = q.s2;
				d.press = q.s2;
				d.deb_cnt = '0;
				d.rpt_cnt = '0;
			end else begin
				d.deb_cnt = q.deb_cnt + 1'b1;
			end
		end else begin
			d.deb_cnt = '0;
		end
		if (q.lvl && q.s2 == q.lvl) begin
			if (q.rpt_cnt == RW'(RPT_CYC - 1)) begin
				d.rpt_cnt = '0;
				d.rpt = 1'b1;
			end else begin
				d.rpt_cnt = q.rpt_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign held = q.lvl;
	assign press = q.press;
	assign repeat_pulse = q.rpt;

	property p_press_edge;
		@(posedge pclk) disable iff (!presetn)
		press |-> held && !$past(held);
	endproperty
	a_press_edge: assert property (p_press_edge)
		else $error("Press pulse without a fresh debounced press");
endmodule // fpk_key_cond

`default_nettype wire

// ==== core/fpk_hold_timer.sv ====
// Purpose: Retriggerable one-shot that holds a level for a fixed time.
// Assumes: start is a one-cycle pulse from pclk logic.
// Notes: A new start during the hold restarts the full interval.
`timescale 1ns/100ps
`default_nettype none

module fpk_hold_timer #(
	parameter int HOLD_CYC = fpk_pkg::MESSAGE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	output var logic active
);
	import fpk_pkg::*;

	localparam int CW = $clog2(HOLD_CYC + 1);

	if (HOLD_CYC < 1) begin : g_chk
		$error("Hold count must be at least one");
	end

	typedef struct packed {
		logic active;
		logic [CW-1:0] cnt;
	} fpk_hold_state_t;

	fpk_hold_state_t q, d;

	always_comb begin
		d = q;
		if (start) begin
			d.active = 1'b1;
			d.cnt = '0;
		end else if (q.active) begin
			if (q.cnt == CW'(HOLD_CYC - 1)) begin
				d.active = 1'b0;
			end else begin
				d.cnt = q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign active = q.active;
endmodule // fpk_hold_timer

`default_nettype wire

// ==== core/fpk_front_panel.sv ====
// Purpose: Front-panel key and indicator controller with an APB port.
// Assumes: Keys and card-detect pins are asynchronous and active high.
// Notes: Only the shift, gain, headroom and range parameters act here.
// Summary of operation
// - One display indicator lit; each display key press advances it.
// - Holding the display key keeps advancing the display function.
// - Six select keys each toggle between two sub-selections and activate.
// - UP and DOWN act only on the active key's lit sub-selection.
// - Shift select key alternates between sign and magnitude.
// - Sign: UP sets positive or turns off if positive; DOWN mirrors.
// - Shift off darkens both sign indicators and freezes the magnitude.
// - Magnitude steps by one thousandth, slow enough for single steps.
// - After ten small steps in one hold, steps become one hundredth.
// - Shift display shows sign and magnitude, or an off message.
// - Two-channel: shift goes in-phase or magnitude per output mode.
// - Gain key toggles times-ten gain on channel one with indicator.
// - Mode select key alternates headroom and range sub-selections.
// - Headroom steps among maximum, middle and stable settings.
// - Each headroom allows only its own sensitivity window.
// - Inconsistent headroom request is refused; sensitivity indicator flashes.
// - Inconsistent new sensitivity moves headroom; headroom indicator flashes.
// - Range steps among wide, mid and low bands.
// - Range without its card is refused; missing-card message shown briefly.
// - No range card at all shows the missing-card message continuously.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module fpk_front_panel #(
	parameter int DEB_CYC = fpk_pkg::DEBOUNCE_CYC,
	parameter int RPT_CYC = fpk_pkg::REPEAT_CYC,
	parameter int MSG_CYC = fpk_pkg::MESSAGE_CYC,
	parameter int BLINK_CYC_P = fpk_pkg::BLINK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire fpk_pkg::fpk_apb_req_t apb_req,
	output var fpk_pkg::fpk_apb_rsp_t apb_rsp,
	input wire logic [fpk_pkg::NKEY-1:0] key_raw,
	input wire logic [2:0] card_present_raw,
	output var fpk_pkg::fpk_panel_out_t panel
);
	import fpk_pkg::*;

	localparam int DW = $clog2(NDISP);
	localparam int BW = $clog2(BLINK_CYC_P + 1);

	if (BLINK_CYC_P < 1 || NDISP < 2) begin : g_chk
		$error("Blink count must be positive and two displays present");
	end

	typedef struct packed {
		logic [2:0] crd_s1;
		logic [2:0] crd_s2;
		logic [DW-1:0] disp;
		logic [2:0] act_sel;
		logic [NSEL-1:0] subsel;
		fpk_sign_t sign;
		logic [MAG_W-1:0] mag;
		logic [3:0] step_cnt;
		logic shift_to_mag;
		logic gain;
		fpk_headroom_t headroom;
		fpk_range_t range;
		logic [SENS_W-1:0] sens;
		logic two_ch;
		fpk_omode_t omode;
		logic [BW-1:0] blink_cnt;
		logic blink;
		fpk_apb_rsp_t rsp;
		fpk_panel_out_t out;
	} fpk_front_state_t;

	fpk_front_state_t q, d;
	logic [NKEY-1:0] key_held, key_press, key_rpt;
	logic [NHOLD-1:0] hold_start, hold_act;
	logic setup, wr_en, up_ev, dn_ev, tgt_mag;
	fpk_reg_t rsel;
	logic [3:0] cnt_now;
	logic [MAG_W-1:0] step;
	logic [SENS_W-1:0] new_sens;
	fpk_headroom_t hr_req;
	fpk_range_t rng_req;

	function automatic fpk_reg_t reg_sel(input logic [ADDR_W-1:0] a);
		if (a == ADDR_CTRL) begin
			return REG_CTRL;
		end else if (a == ADDR_SENS) begin
			return REG_SENS;
		end else if (a == ADDR_STATUS) begin
			return REG_STATUS;
		end else if (a == ADDR_SHIFT) begin
			return REG_SHIFT;
		end else begin
			return REG_NONE;
		end
	endfunction

	// Sensitivity window for each headroom setting
	function automatic logic hr_ok(input logic [SENS_W-1:0] s,
			input fpk_headroom_t h);
		case (h)
			HR_STABLE: return s <= SENS_STABLE_HI;
			HR_MIDDLE: return s >= SENS_MID_LO && s <= SENS_MID_HI;
			default: return s >= SENS_MAXHR_LO && s <= SENS_LAST;
		endcase
	endfunction

	// Nearest headroom that accepts the given sensitivity
	function automatic fpk_headroom_t hr_fix(input logic [SENS_W-1:0] s);
		if (s < SENS_MID_LO) begin
			return HR_STABLE;
		end else if (s > SENS_MID_HI) begin
			return HR_MAX;
		end else begin
			return HR_MIDDLE;
		end
	endfunction

	function automatic fpk_headroom_t hr_step(input fpk_headroom_t h,
			input logic up);
		if (up) begin
			return (h == HR_MAX) ? h : fpk_headroom_t'(h + 2'h1);
		end else begin
			return (h == HR_STABLE) ? h : fpk_headroom_t'(h - 2'h1);
		end
	endfunction

	function automatic fpk_range_t rng_step(input fpk_range_t r,
			input logic up);
		if (up) begin
			return (r == RNG_LOW) ? r : fpk_range_t'(r + 2'h1);
		end else begin
			return (r == RNG_WIDE) ? r : fpk_range_t'(r - 2'h1);
		end
	endfunction

	for (genvar k = 0; k < NKEY; k++) begin : g_key
		fpk_key_cond #(
			.DEB_CYC(DEB_CYC),
			.RPT_CYC(RPT_CYC)
		) u_cond (
			.pclk(pclk),
			.presetn(presetn),
			.key_raw(key_raw[k]),
			.held(key_held[k]),
			.press(key_press[k]),
			.repeat_pulse(key_rpt[k])
		);
	end

	// Message hold, headroom flash and sensitivity flash share one duration
	for (genvar h = 0; h < NHOLD; h++) begin : g_hold
		fpk_hold_timer #(
			.HOLD_CYC(MSG_CYC)
		) u_hold (
			.pclk(pclk),
			.presetn(presetn),
			.start(hold_start[h]),
			.active(hold_act[h])
		);
	end

	always_comb begin
		d = q;
		hold_start = '0;
		cnt_now = '0;
		step = STEP_SMALL;
		d.crd_s1 = card_present_raw;
		d.crd_s2 = q.crd_s1;
		up_ev = key_press[KEY_UP] || key_rpt[KEY_UP];
		dn_ev = key_press[KEY_DOWN] || key_rpt[KEY_DOWN];
		tgt_mag = q.two_ch && (q.omode == OMODE_MAG
			|| q.omode == OMODE_LOGMAG);
		hr_req = hr_step(q.headroom, key_press[KEY_UP]);
		rng_req = rng_step(q.range, key_press[KEY_UP]);

		if (key_press[KEY_DISPLAY] || key_rpt[KEY_DISPLAY]) begin
			d.disp = (q.disp == DW'(NDISP - 1)) ? '0
				: q.disp + 1'b1;
		end
		for (int i = 0; i < NSEL; i++) begin
			if (key_press[KEY_SEL0 + i]) begin
				d.act_sel = 3'(i);
				d.subsel[i] = !q.subsel[i];
			end
		end
		if (key_press[KEY_GAIN]) begin
			d.gain = !q.gain;
		end

		if (!key_held[KEY_UP] && !key_held[KEY_DOWN]) begin
			d.step_cnt = '0;
		end
		// UP and DOWN reach only the active key's lit sub-selection
		if (q.act_sel == SEL_SHIFT) begin
			if (!q.subsel[SEL_SHIFT]) begin
				if (key_press[KEY_UP] && !key_press[KEY_DOWN]) begin
					d.sign = (q.sign == SIGN_POS) ? SIGN_OFF
						: SIGN_POS;
					d.shift_to_mag = tgt_mag;
				end else if (key_press[KEY_DOWN] && !key_press[KEY_UP]) begin
					d.sign = (q.sign == SIGN_NEG) ? SIGN_OFF
						: SIGN_NEG;
					d.shift_to_mag = tgt_mag;
				end
			end else if (q.sign != SIGN_OFF && up_ev != dn_ev) begin
				cnt_now = (key_press[KEY_UP] || key_press[KEY_DOWN]) ? '0
					: q.step_cnt;
				step = (cnt_now >= SMALL_STEP_LIMIT) ? STEP_LARGE
					: STEP_SMALL;
				if (cnt_now < SMALL_STEP_LIMIT) begin
					d.step_cnt = cnt_now + 4'h1;
				end else begin
					d.step_cnt = cnt_now;
				end
				if (up_ev) begin
					d.mag = (q.mag > MAG_FULL - step) ? MAG_FULL
						: q.mag + step;
				end else begin
					d.mag = (q.mag < step) ? '0 : q.mag - step;
				end
				d.shift_to_mag = tgt_mag;
			end
		end else if (q.act_sel == SEL_MODE
				&& key_press[KEY_UP] != key_press[KEY_DOWN]) begin
			if (!q.subsel[SEL_MODE]) begin
				if (hr_ok(q.sens, hr_req)) begin
					d.headroom = hr_req;
				end else begin
					hold_start[HOLD_SENS] = 1'b1;
				end
			end else if (q.crd_s2[rng_req]) begin
				d.range = rng_req;
			end else begin
				hold_start[HOLD_ERR] = 1'b1;
			end
		end

		// Register port: data and answer are set up one cycle ahead
		setup = apb_req.psel && !apb_req.penable;
		wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite
			&& q.rsp.pready;
		rsel = reg_sel(apb_req.paddr);
		d.rsp.pready = setup;
		d.rsp.pslverr = setup && rsel == REG_NONE;
		d.rsp.prdata = '0;
		if (setup && !apb_req.pwrite) begin
			if (rsel == REG_CTRL) begin
				d.rsp.prdata[CTRL_TWOCH_BIT] = q.two_ch;
				d.rsp.prdata[CTRL_OMODE_LSB +: 2] = q.omode;
			end else if (rsel == REG_SENS) begin
				d.rsp.prdata[SENS_W-1:0] = q.sens;
			end else if (rsel == REG_STATUS) begin
				d.rsp.prdata = 32'({q.shift_to_mag, q.range, q.headroom,
					q.sign, q.gain, q.subsel, q.act_sel, q.disp});
			end else if (rsel == REG_SHIFT) begin
				d.rsp.prdata[MAG_W-1:0] = q.mag;
			end
		end
		new_sens = (apb_req.pwdata[SENS_W-1:0] > SENS_LAST) ? SENS_LAST
			: apb_req.pwdata[SENS_W-1:0];
		if (wr_en && rsel == REG_CTRL) begin
			d.two_ch = apb_req.pwdata[CTRL_TWOCH_BIT];
			d.omode = fpk_omode_t'(apb_req.pwdata[CTRL_OMODE_LSB +: 2]);
		end else if (wr_en && rsel == REG_SENS) begin
			d.sens = new_sens;
			// Sensitivity dominates: headroom follows it
			if (!hr_ok(new_sens, d.headroom)) begin
				d.headroom = hr_fix(new_sens);
				hold_start[HOLD_HR] = 1'b1;
			end
		end

		if (hold_act[HOLD_HR] || hold_act[HOLD_SENS]) begin
			if (q.blink_cnt == BW'(BLINK_CYC_P - 1)) begin
				d.blink_cnt = '0;
				d.blink = !q.blink;
			end else begin
				d.blink_cnt = q.blink_cnt + 1'b1;
			end
		end else begin
			d.blink_cnt = '0;
			d.blink = 1'b0;
		end

		d.out.disp_led = NDISP'(1) << d.disp;
		d.out.sel_led = NSEL'(1) << d.act_sel;
		for (int i = 0; i < NSEL; i++) begin
			d.out.subsel_led[2*i +: 2] = d.subsel[i] ? 2'h2 : 2'h1;
		end
		d.out.shift_pos_led = d.sign == SIGN_POS;
		d.out.shift_neg_led = d.sign == SIGN_NEG;
		d.out.gain_led = d.gain;
		d.out.headroom_led = (hold_act[HOLD_HR] && !d.blink) ? 3'h0
			: 3'h1 << d.headroom;
		d.out.range_led = 3'h1 << d.range;
		d.out.sens_flash = hold_act[HOLD_SENS] && d.blink;
		d.out.shift_to_mag = d.shift_to_mag;
		d.out.meter_neg = d.sign == SIGN_NEG;
		d.out.meter_mag = d.mag;
		if (q.crd_s2 == 3'h0 || hold_act[HOLD_ERR]) begin
			d.out.meter_mode = MTR_MISSING_CARD;
		end else if (d.disp == DW'(DISP_SHIFT)) begin
			d.out.meter_mode = (d.sign == SIGN_OFF) ? MTR_OFF
				: MTR_SHIFT;
		end else begin
			d.out.meter_mode = MTR_VALUE;
		end
	end

	// Panel shows its power-on LEDs at once, so no blank frame follows reset
	function automatic fpk_front_state_t reset_state();
		fpk_front_state_t s;
		s = '0;
		s.out.disp_led = NDISP'(1);
		s.out.sel_led = NSEL'(1);
		s.out.subsel_led = {NSEL{2'h1}};
		s.out.headroom_led = 3'h1;
		s.out.range_led = 3'h1;
		s.out.meter_mode = MTR_MISSING_CARD;
		return s;
	endfunction

	localparam fpk_front_state_t Q_RST = reset_state();

	// State zero at reset: shift off, gain off, first sub-selections, 5 V
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= Q_RST;
		end else begin
			q <= d;
		end
	end

	assign apb_rsp = q.rsp;
	assign panel = q.out;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_disp_onehot;
		$onehot(panel.disp_led) && panel.disp_led == NDISP'(1) << q.disp;
	endproperty
	a_disp_onehot: assert property (p_disp_onehot)
		else $error("Display indicators not one-hot");

	property p_disp_adv;
		key_press[KEY_DISPLAY] || key_rpt[KEY_DISPLAY]
			|=> q.disp != $past(q.disp);
	endproperty
	a_disp_adv: assert property (p_disp_adv)
		else $error("Display did not advance");

	property p_shift_toggle;
		key_press[KEY_SEL0] |=> q.act_sel == SEL_SHIFT
			&& q.subsel[SEL_SHIFT] != $past(q.subsel[SEL_SHIFT]);
	endproperty
	a_shift_toggle: assert property (p_shift_toggle)
		else $error("Shift select did not alternate");

	property p_off_freeze;
		q.sign == SIGN_OFF |=> q.mag == $past(q.mag)
			##1 !panel.shift_pos_led && !panel.shift_neg_led
				|| q.sign != SIGN_OFF;
	endproperty
	a_off_freeze: assert property (p_off_freeze)
		else $error("Magnitude moved or sign lit while shift off");

	property p_large_step;
		q.act_sel == SEL_SHIFT && q.subsel[SEL_SHIFT] && q.sign != SIGN_OFF
			&& key_rpt[KEY_UP] && !key_held[KEY_DOWN]
			&& q.step_cnt == SMALL_STEP_LIMIT
			&& q.mag <= MAG_FULL - STEP_LARGE
			|=> q.mag == $past(q.mag) + STEP_LARGE;
	endproperty
	a_large_step: assert property (p_large_step)
		else $error("Held key did not use the large step");

	property p_gain_toggle;
		key_press[KEY_GAIN] |=> panel.gain_led != $past(panel.gain_led);
	endproperty
	a_gain_toggle: assert property (p_gain_toggle)
		else $error("Gain indicator did not toggle");

	property p_hr_consistent;
		hr_ok(q.sens, q.headroom);
	endproperty
	a_hr_consistent: assert property (p_hr_consistent)
		else $error("Headroom inconsistent with sensitivity");

	property p_hr_refuse;
		q.act_sel == SEL_MODE && !q.subsel[SEL_MODE]
			&& key_press[KEY_UP] && !key_press[KEY_DOWN]
			&& !hr_ok(q.sens, hr_step(q.headroom, 1'b1))
			|=> $stable(q.headroom) && hold_act[HOLD_SENS];
	endproperty
	a_hr_refuse: assert property (p_hr_refuse)
		else $error("Refused headroom changed or no flash");

	property p_range_refuse;
		q.act_sel == SEL_MODE && q.subsel[SEL_MODE]
			&& key_press[KEY_UP] && !key_press[KEY_DOWN]
			&& !q.crd_s2[rng_step(q.range, 1'b1)]
			|=> $stable(q.range) ##1 panel.meter_mode == MTR_MISSING_CARD;
	endproperty
	a_range_refuse: assert property (p_range_refuse)
		else $error("Missing card range taken or no message");

	property p_no_card;
		q.crd_s2 == 3'h0 |=> panel.meter_mode == MTR_MISSING_CARD;
	endproperty
	a_no_card: assert property (p_no_card)
		else $error("No card present but message absent");
endmodule // fpk_front_panel

`default_nettype wire

// ==== tb/fpk_operator.sv ====
// Purpose: Operator at the front panel, pressing one key at a time.
// Assumes: go is a one-cycle request; key and len stay put while busy.
// Notes: Each press bounces for three cycles, is held until cycle len, then released.
`timescale 1ns/100ps
`default_nettype none

module fpk_operator (
	input wire logic pclk,
	input wire logic go,
	input wire logic [3:0] key,
	input wire logic [15:0] len,
	output var logic busy,
	output var logic [fpk_pkg::NKEY-1:0] key_raw
);
	import fpk_pkg::*;
	int cnt;

	initial begin
		busy = 1'b0;
		key_raw = '0;
		cnt = 0;
	end

	always @(posedge pclk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			cnt <= 0;
		end else if (busy) begin
			cnt <= cnt + 1;
			// Contact bounce at the start; a human is no clean source
			key_raw[key] <= (cnt < 3) ? cnt[0] : (cnt < len);
			// Stay away from the keys long enough for release to register
			if (cnt == len + 12) begin
				busy <= 1'b0;
			end
		end
	end
endmodule // fpk_operator

`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the front panel key controller.
// Assumes: Shortened debounce, repeat, message and blink counts.
// Notes: Keys come from the operator model; registers over APB.
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import fpk_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	fpk_apb_req_t apb_req = '0;
	fpk_apb_rsp_t apb_rsp;
	fpk_panel_out_t panel;
	logic [NKEY-1:0] key_raw;
	logic [2:0] card_present_raw = 3'h3;
	logic go = 1'b0;
	logic [3:0] key = 4'h0;
	logic [15:0] len = 16'h000a;
	logic busy;
	logic [31:0] rd;
	logic err;
	logic f;
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;

	always #50 pclk = ~pclk;

	fpk_front_panel #(.DEB_CYC(4), .RPT_CYC(20), .MSG_CYC(30),
			.BLINK_CYC_P(3)) u_dut (
		.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .key_raw(key_raw),
		.card_present_raw(card_present_raw), .panel(panel));

	fpk_operator u_op (.pclk(pclk), .go(go), .key(key), .len(len),
		.busy(busy), .key_raw(key_raw));

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic press(input int k, input int n);
		go <= 1'b1;
		key <= 4'(k);
		len <= 16'(n);
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		while (busy === 1'b1) @(posedge pclk);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= wr;
		apb_req.paddr <= a;
		apb_req.pwdata <= d;
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic t_reset();
		check("disp", 32'(panel.disp_led), 32'h0000_0001);
		check("subsel", 32'(panel.subsel_led), 32'h0000_0555);
		check("sign", {panel.shift_pos_led, panel.shift_neg_led}, 0);
		check("gain", 32'(panel.gain_led), 32'h0000_0000);
		apb(1'b0, 8'h10, 32'h0000_0000);
		check("unmapped", 32'(err), 32'h0000_0001);
		$display("reset test done");
	endtask

	task automatic t_display();
		press(KEY_DISPLAY, 10);
		check("disp", 32'(panel.disp_led), 32'h0000_0002);
		check("meter", 32'(panel.meter_mode), 32'(MTR_OFF));
		// Held long enough for exactly one repeat after the press
		press(KEY_DISPLAY, 30);
		check("disp", 32'(panel.disp_led), 32'h0000_0008);
		$display("display test done");
	endtask

	task automatic t_shift();
		press(KEY_SEL0, 10);
		check("sel", 32'(panel.sel_led), 32'h0000_0001);
		check("sub", 32'(panel.subsel_led[1:0]), 32'h0000_0002);
		press(KEY_SEL0, 10);
		check("sub", 32'(panel.subsel_led[1:0]), 32'h0000_0001);
		press(KEY_UP, 10);
		check("sign", {panel.shift_pos_led, panel.shift_neg_led}, 2);
		check("target", 32'(panel.shift_to_mag), 32'h0000_0000);
		press(KEY_UP, 10);
		check("sign", {panel.shift_pos_led, panel.shift_neg_led}, 0);
		press(KEY_SEL0, 10);
		press(KEY_UP, 10);
		apb(1'b0, ADDR_SHIFT, 32'h0000_0000);
		check("mag", rd, 32'h0000_0000);
		press(KEY_SEL0, 10);
		press(KEY_DOWN, 10);
		check("sign", {panel.shift_pos_led, panel.shift_neg_led}, 1);
		apb(1'b1, ADDR_CTRL, 32'h0000_0005);
		press(KEY_SEL0, 10);
		press(KEY_UP, 10);
		apb(1'b0, ADDR_SHIFT, 32'h0000_0000);
		check("mag", rd, 32'h0000_0001);
		check("target", 32'(panel.shift_to_mag), 32'h0000_0001);
		// Press plus twelve repeats: ten small steps, then three large
		press(KEY_UP, 250);
		apb(1'b0, ADDR_SHIFT, 32'h0000_0000);
		check("mag", rd, 32'h0000_0029);
		press(KEY_DOWN, 10);
		apb(1'b0, ADDR_SHIFT, 32'h0000_0000);
		check("mag", rd, 32'h0000_0028);
		// Four presses wrap the display from the fourth function to shift
		repeat (4) press(KEY_DISPLAY, 10);
		check("meter", 32'(panel.meter_mode), 32'(MTR_SHIFT));
		check("neg", 32'(panel.meter_neg), 32'h0000_0001);
		check("meter mag", 32'(panel.meter_mag), 32'h0000_0028);
		$display("shift test done");
	endtask

	task automatic t_gain();
		press(KEY_GAIN, 10);
		check("gain", 32'(panel.gain_led), 32'h0000_0001);
		press(KEY_GAIN, 10);
		check("gain", 32'(panel.gain_led), 32'h0000_0000);
		$display("gain test done");
	endtask

	task automatic t_mode();
		press(KEY_SEL0 + 1, 10);
		check("sel", 32'(panel.sel_led), 32'h0000_0002);
		check("sub", 32'(panel.subsel_led[3:2]), 32'h0000_0002);
		press(KEY_UP, 10);
		check("range", 32'(panel.range_led), 32'h0000_0002);
		apb(1'b0, ADDR_SHIFT, 32'h0000_0000);
		check("mag", rd, 32'h0000_0028);
		press(KEY_UP, 10);
		check("range", 32'(panel.range_led), 32'h0000_0002);
		check("meter", 32'(panel.meter_mode), 32'(MTR_MISSING_CARD));
		repeat (40) @(posedge pclk);
		check("brief", 32'(panel.meter_mode == MTR_MISSING_CARD), 0);
		press(KEY_SEL0 + 1, 10);
		press(KEY_UP, 10);
		f = 1'b0;
		repeat (12) begin
			@(posedge pclk);
			f = f | panel.sens_flash;
		end
		check("flash", 32'(f), 32'h0000_0001);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		check("hr", 32'(rd[16:15]), 32'(HR_STABLE));
		apb(1'b1, ADDR_SENS, 32'h0000_000a);
		press(KEY_UP, 10);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		check("hr", 32'(rd[16:15]), 32'(HR_MIDDLE));
		apb(1'b1, ADDR_SENS, 32'h0000_0012);
		f = 1'b0;
		repeat (6) begin
			@(posedge pclk);
			f = f | (panel.headroom_led == 3'h0);
		end
		check("hr flash", 32'(f), 32'h0000_0001);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		check("hr", 32'(rd[16:15]), 32'(HR_MAX));
		$display("mode test done");
	endtask

	task automatic t_card();
		card_present_raw <= 3'h0;
		repeat (8) @(posedge pclk);
		check("meter", 32'(panel.meter_mode), 32'(MTR_MISSING_CARD));
		$display("card test done");
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_reset();
		t_display();
		t_shift();
		t_gain();
		t_mode();
		t_card();
		final_report();
	end

	// Whole run needs about a thousand cycles; far beyond that is a hang
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			$display("timeout after %0d cycles", cyc);
			final_report();
		end
	end
endmodule // testbench

`default_nettype wire
